// [logic/pod_bit_page.sv]
`timescale 1ns/1ns
`include "pod_defines.svh"
module pod_bit_page import pod_pkg::*; (
	input wire logic [7:0] opByte, // second or fourth opcode byte
	input wire logic indexed, // reached through an index prefix
	output pod_dec_t dec // decoded bit-page operation
);
	// ------------------------------------------------------------
	// bit-operation page decode
	// ------------------------------------------------------------
	always_comb begin
		dec = '0;
		dec.op.kind = OP_NOP;
		dec.op.opcode = opByte;
		dec.op.bitNum = opByte[5:3];
		dec.op.regSel = opByte[2:0];
		case (opByte[7:6])
			2'h0: begin
				// (RULE2) upper row-3 shift
				if (opByte[5:3] == 3'h7) begin
					dec.op.kind = OP_LSR;
				end else if (opByte[5:3] == 3'h6) begin
					// blank lower half of row 3
					dec.op.kind = OP_NOP;
				end else begin
					dec.op.kind = OP_ROTSH;
				end
			end
			// (RULE3) bit test rows
			2'h1: dec.op.kind = OP_BTEST;
			// (RULE4) bit clear rows
			2'h2: dec.op.kind = OP_BCLR;
			// (RULE5) bit force rows
			2'h3: dec.op.kind = OP_BSET;
			default: dec.op.kind = OP_NOP;
		endcase
		// (RULE20) indexed needs memory operand
		if (indexed && opByte[2:0] != `POD_OPND_MEM) begin
			dec.op.kind = OP_NOP;
		end
	end
endmodule

// [logic/pod_defines.svh]
`ifndef POD_DEFINES_SVH
`define POD_DEFINES_SVH
// ----------------------------------------------------------------
// prefix bytes
// ----------------------------------------------------------------
`define POD_PFX_BIT 8'hcb
`define POD_PFX_EXT 8'hed
`define POD_PFX_IDX1 8'hdd
`define POD_PFX_IDX2 8'hfd
// ----------------------------------------------------------------
// operand and index codes
// ----------------------------------------------------------------
`define POD_OPND_MEM 3'h6
`define POD_IDX_NONE 2'h0
`define POD_IDX_FIRST 2'h1
`define POD_IDX_SECOND 2'h2
`define POD_IMODE_RST 2'h0
`define POD_IMM_NONE 2'h0
`define POD_IMM_BYTE 2'h1
`define POD_IMM_WORD 2'h2
// ----------------------------------------------------------------
// extended page single codes
// ----------------------------------------------------------------
`define POD_EXT_NEG 8'h44
`define POD_EXT_RETNMI 8'h45
`define POD_EXT_RETIRQ 8'h4d
`define POD_EXT_IM0 8'h46
`define POD_EXT_IM1 8'h56
`define POD_EXT_IM2 8'h5e
`define POD_EXT_A2VEC 8'h47
`define POD_EXT_VEC2A 8'h57
`define POD_EXT_A2RFSH 8'h4f
`define POD_EXT_RFSH2A 8'h5f
`define POD_EXT_NROTR 8'h67
`define POD_EXT_NROTL 8'h6f
// ----------------------------------------------------------------
// index page single codes
// ----------------------------------------------------------------
`define POD_IDX_LDIMM 8'h21
`define POD_IDX_STABS 8'h22
`define POD_IDX_INC 8'h23
`define POD_IDX_LDABS 8'h2a
`define POD_IDX_DEC 8'h2b
`define POD_IDX_INCM 8'h34
`define POD_IDX_DECM 8'h35
`define POD_IDX_LDMN 8'h36
`define POD_IDX_STOREM 8'h76
`define POD_IDX_POP 8'he1
`define POD_IDX_EXSP 8'he3
`define POD_IDX_PUSH 8'he5
`define POD_IDX_JP 8'he9
`define POD_IDX_LDSP 8'hf9
`endif

// [logic/pod_ext_page.sv]
`timescale 1ns/1ns
`include "pod_defines.svh"
module pod_ext_page import pod_pkg::*; (
	input wire logic [7:0] opByte, // byte after the extended prefix
	output pod_dec_t dec // decoded extended-page operation
);
	// ------------------------------------------------------------
	// extended page decode
	// ------------------------------------------------------------
	always_comb begin
		dec = '0;
		dec.op.kind = OP_NOP;
		dec.op.opcode = opByte;
		dec.op.regSel = opByte[5:3];
		dec.op.pairSel = opByte[5:4];
		dec.op.bitNum = opByte[5:3];
		dec.op.blkDown = opByte[3];
		dec.op.blkRepeat = opByte[4];
		if (opByte[7:6] == 2'h1) begin
			case (opByte[2:0])
				// (RULE6) port in and out via C
				3'h0: dec.op.kind = OP_PIN;
				3'h1: dec.op.kind = OP_POUT;
				// (RULE7) wide carry arithmetic
				3'h2: dec.op.kind = opByte[3] ? OP_ADDW : OP_SUBW;
				3'h3: begin
					// (RULE8) pair to absolute address
					dec.op.kind = opByte[3] ? OP_LDPAIR : OP_STPAIR;
					dec.immCnt = `POD_IMM_WORD;
				end
				default: begin
					case (opByte)
						// (RULE9) negate and returns
						`POD_EXT_NEG: dec.op.kind = OP_NEG;
						`POD_EXT_RETNMI: dec.op.kind = OP_RETNMI;
						`POD_EXT_RETIRQ: dec.op.kind = OP_RETIRQ;
						// (RULE10) interrupt mode select
						`POD_EXT_IM0: dec.op.kind = OP_IMSET;
						`POD_EXT_IM1: dec.op.kind = OP_IMSET;
						`POD_EXT_IM2: dec.op.kind = OP_IMSET;
						// (RULE11) vector and refresh copies
						`POD_EXT_A2VEC: dec.op.kind = OP_A2VEC;
						`POD_EXT_VEC2A: dec.op.kind = OP_VEC2A;
						`POD_EXT_A2RFSH: dec.op.kind = OP_A2RFSH;
						`POD_EXT_RFSH2A: dec.op.kind = OP_RFSH2A;
						// (RULE12) nibble rotates
						`POD_EXT_NROTR: dec.op.kind = OP_NROTR;
						`POD_EXT_NROTL: dec.op.kind = OP_NROTL;
						// (RULE22) blank slots do nothing
						default: dec.op.kind = OP_NOP;
					endcase
				end
			endcase
		end else if (opByte[7:5] == 3'h5 && !opByte[2]) begin
			// (RULE13) block ops, direction in bit 3
			// (RULE14) repeating forms in row B
			case (opByte[1:0])
				2'h0: dec.op.kind = OP_BCOPY;
				2'h1: dec.op.kind = OP_BCMP;
				2'h2: dec.op.kind = OP_BIN;
				default: dec.op.kind = OP_BOUT;
			endcase
		end
	end
endmodule

// [logic/pod_pkg.sv]
package pod_pkg;
	// ------------------------------------------------------------
	// operation kinds handed to the execute stage
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		OP_NOP = 6'b000000, OP_BASE = 6'b000001, OP_ROTSH = 6'b000010,
		OP_LSR = 6'b000011, OP_BTEST = 6'b000100, OP_BCLR = 6'b000101,
		OP_BSET = 6'b000110, OP_PIN = 6'b000111, OP_POUT = 6'b001000,
		OP_SUBW = 6'b001001, OP_ADDW = 6'b001010, OP_STPAIR = 6'b001011,
		OP_LDPAIR = 6'b001100, OP_NEG = 6'b001101, OP_RETNMI = 6'b001110,
		OP_RETIRQ = 6'b001111, OP_IMSET = 6'b010000, OP_A2VEC = 6'b010001,
		OP_VEC2A = 6'b010010, OP_A2RFSH = 6'b010011, OP_RFSH2A = 6'b010100,
		OP_NROTR = 6'b010101, OP_NROTL = 6'b010110, OP_BCOPY = 6'b010111,
		OP_BCMP = 6'b011000, OP_BIN = 6'b011001, OP_BOUT = 6'b011010,
		OP_XSUBST = 6'b011011, OP_XPOP = 6'b011100, OP_XEXSP = 6'b011101,
		OP_XPUSH = 6'b011110, OP_XJP = 6'b011111, OP_XLDSP = 6'b100000,
		OP_XLDIMM = 6'b100001, OP_XSTABS = 6'b100010, OP_XLDABS = 6'b100011,
		OP_XINC = 6'b100100, OP_XDEC = 6'b100101, OP_XADD = 6'b100110
	} pod_kind_t;

	// decoder sequencing states
	typedef enum logic [2:0] {
		ST_FIRST = 3'b000, ST_BIT = 3'b001, ST_EXT = 3'b010,
		ST_IDX = 3'b011, ST_XDISP = 3'b100, ST_XOP = 3'b101,
		ST_DISP = 3'b110, ST_IMM = 3'b111
	} pod_state_t;

	// one decoded operation
	typedef struct packed {
		pod_kind_t kind;
		logic [7:0] opcode;
		logic [2:0] bitNum;
		logic [2:0] regSel;
		logic [1:0] pairSel;
		logic [1:0] idxSel;
		logic blkDown;
		logic blkRepeat;
		logic [7:0] disp;
		logic [15:0] imm;
	} pod_op_t;

	// page decode result plus the operand bytes still to come
	typedef struct packed {
		pod_op_t op;
		logic needDisp;
		logic [1:0] immCnt;
	} pod_dec_t;
endpackage

// [logic/prefixed_opcode_decoder.sv]
`timescale 1ns/1ns
`include "pod_defines.svh"
// Notes on behaviour
// (RULE1) byte after bit prefix uses bit page
// (RULE2) upper row 3 is logical shift right
// (RULE3) rows 4 to 7 are bit test
// (RULE4) rows 8 to B are bit clear
// (RULE5) rows C to F are bit force
// (RULE6) extended column 0/1 port in/out via C
// (RULE7) columns 2/A wide subtract/add into pointer
// (RULE8) columns 3/B store/load pair, absolute address
// (RULE9) 44 negate, 45 and 4D returns
// (RULE10) 46/56/5E set and hold interrupt mode
// (RULE11) vector and refresh register copies
// (RULE12) 67/6F nibble rotates with memory
// (RULE13) A0-A3, A8-AB block ops up/down
// (RULE14) B0-B3, B8-BB repeating block ops
// (RULE15) first index prefix substitutes first index
// (RULE16) second index prefix substitutes second index
// (RULE17) indexed memory takes signed displacement
// (RULE18) E1 E3 E5 E9 F9 stack and jump
// (RULE19) 21 22 2A 23 2B index loads, steps
// (RULE20) first index bit page needs memory operand
// (RULE21) second index bit page uses displacement
// (RULE22) blank positions decode to no operation
module prefixed_opcode_decoder import pod_pkg::*; (
	input wire logic ref_clk, // core clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic byteValid, // fetch presents a byte this cycle
	input wire logic [7:0] byteData, // fetched opcode or operand byte
	input wire logic flush, // abandon any partial sequence
	output logic opValid, // one-cycle pulse with op
	output pod_op_t op, // decoded operation
	output logic [1:0] intMode, // held interrupt mode
	output logic busy // inside a multi-byte sequence
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pod_state_t state_ff; // sequencing state
	pod_state_t nxt_state; // next sequencing state
	logic [1:0] idxSel_ff; // active index register
	logic [1:0] nxt_idxSel; // next index selection
	pod_op_t pend_ff; // operation awaiting operand bytes
	pod_op_t nxt_pend; // next pending operation
	logic [1:0] immLeft_ff; // immediate bytes still expected
	logic [1:0] nxt_immLeft; // next immediate count
	logic immHigh_ff; // next immediate byte is the high one
	logic nxt_immHigh; // next high-byte marker
	logic [7:0] xdisp_ff; // displacement of an indexed bit op
	logic [7:0] nxt_xdisp; // next indexed bit displacement
	pod_op_t op_ff; // registered output operation
	logic opValid_ff; // registered output strobe
	logic emit; // an operation completes this cycle
	pod_op_t emitOp; // the operation that completes
	logic [1:0] imode_ff; // held interrupt mode
	pod_dec_t bitDec; // bit page result
	pod_dec_t extDec; // extended page result
	pod_dec_t idxDec; // index page result

	// ------------------------------------------------------------
	// page decoders
	// ------------------------------------------------------------
	// the bit decoder sees the same byte on both the plain page and
	// the indexed fourth byte; only the indexed flag differs
	pod_bit_page u_bit (
		.opByte(byteData),
		.indexed(state_ff == ST_XOP),
		.dec(bitDec)
	);

	pod_ext_page u_ext (
		.opByte(byteData),
		.dec(extDec)
	);

	// ------------------------------------------------------------
	// index page decode
	// ------------------------------------------------------------
	// true for a base-page position that reads or writes memory at
	// the pointer pair and so needs a displacement when indexed
	function automatic logic memForm(input logic [7:0] b);
		logic ld;
		logic st;
		logic alu;
		ld = (b[7:6] == 2'h1) && (b[2:0] == `POD_OPND_MEM) &&
			(b != `POD_IDX_STOREM);
		st = (b[7:3] == 5'h0e) && (b[2:0] != `POD_OPND_MEM);
		alu = (b[7:6] == 2'h2) && (b[2:0] == `POD_OPND_MEM);
		memForm = ld || st || alu;
	endfunction

	always_comb begin
		idxDec = '0;
		idxDec.op.kind = OP_NOP;
		idxDec.op.opcode = byteData;
		idxDec.op.regSel = byteData[2:0];
		idxDec.op.pairSel = byteData[5:4];
		idxDec.op.bitNum = byteData[5:3];
		// (RULE15) first index takes pointer's place
		// (RULE16) second index takes pointer's place
		idxDec.op.idxSel = idxSel_ff;
		case (byteData)
			// (RULE19) immediate, absolute, steps
			`POD_IDX_LDIMM: begin
				idxDec.op.kind = OP_XLDIMM;
				idxDec.immCnt = `POD_IMM_WORD;
			end
			`POD_IDX_STABS: begin
				idxDec.op.kind = OP_XSTABS;
				idxDec.immCnt = `POD_IMM_WORD;
			end
			`POD_IDX_LDABS: begin
				idxDec.op.kind = OP_XLDABS;
				idxDec.immCnt = `POD_IMM_WORD;
			end
			`POD_IDX_INC: idxDec.op.kind = OP_XINC;
			`POD_IDX_DEC: idxDec.op.kind = OP_XDEC;
			// (RULE17) memory step at index plus d
			`POD_IDX_INCM, `POD_IDX_DECM: begin
				idxDec.op.kind = OP_XSUBST;
				idxDec.needDisp = 1'b1;
			end
			`POD_IDX_LDMN: begin
				idxDec.op.kind = OP_XSUBST;
				idxDec.needDisp = 1'b1;
				idxDec.immCnt = `POD_IMM_BYTE;
			end
			// (RULE18) stack and jump forms
			`POD_IDX_POP: idxDec.op.kind = OP_XPOP;
			`POD_IDX_EXSP: idxDec.op.kind = OP_XEXSP;
			`POD_IDX_PUSH: idxDec.op.kind = OP_XPUSH;
			`POD_IDX_JP: idxDec.op.kind = OP_XJP;
			`POD_IDX_LDSP: idxDec.op.kind = OP_XLDSP;
			default: begin
				if (byteData[7:6] == 2'h0 && byteData[3:0] == 4'h9) begin
					// wide add, the row picks the source pair
					idxDec.op.kind = OP_XADD;
				end else if (memForm(byteData)) begin
					// (RULE17) load, store, alu at index plus d
					idxDec.op.kind = OP_XSUBST;
					idxDec.needDisp = 1'b1;
				end else begin
					// (RULE22) blank index slot
					idxDec.op.kind = OP_NOP;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	// a page result either completes at once or parks in the
	// pending slot until its displacement and immediates arrive
	always_comb begin
		nxt_state = state_ff;
		nxt_idxSel = idxSel_ff;
		nxt_pend = pend_ff;
		nxt_immLeft = immLeft_ff;
		nxt_immHigh = immHigh_ff;
		nxt_xdisp = xdisp_ff;
		emit = 1'b0;
		emitOp = pend_ff;
		if (flush) begin
			// abandon partial sequence, nothing is emitted
			nxt_state = ST_FIRST;
			nxt_idxSel = `POD_IDX_NONE;
		end else if (byteValid) begin
			case (state_ff)
				ST_FIRST: begin
					nxt_idxSel = `POD_IDX_NONE;
					case (byteData)
						// (RULE1) bit prefix opens bit page
						`POD_PFX_BIT: nxt_state = ST_BIT;
						`POD_PFX_EXT: nxt_state = ST_EXT;
						`POD_PFX_IDX1: begin
							nxt_state = ST_IDX;
							nxt_idxSel = `POD_IDX_FIRST;
						end
						`POD_PFX_IDX2: begin
							nxt_state = ST_IDX;
							nxt_idxSel = `POD_IDX_SECOND;
						end
						default: begin
							// unprefixed byte passes straight on
							emit = 1'b1;
							emitOp = '0;
							emitOp.kind = OP_BASE;
							emitOp.opcode = byteData;
						end
					endcase
				end
				ST_BIT: begin
					// (RULE1) second byte from bit page
					emit = 1'b1;
					emitOp = bitDec.op;
					nxt_state = ST_FIRST;
				end
				ST_EXT: begin
					if (extDec.immCnt != `POD_IMM_NONE) begin
						nxt_pend = extDec.op;
						nxt_immLeft = extDec.immCnt;
						nxt_immHigh = 1'b0;
						nxt_state = ST_IMM;
					end else begin
						emit = 1'b1;
						emitOp = extDec.op;
						nxt_state = ST_FIRST;
					end
				end
				ST_IDX: begin
					if (byteData == `POD_PFX_BIT) begin
						nxt_state = ST_XDISP;
					end else if (byteData == `POD_PFX_IDX1) begin
						// a later index prefix overrides the earlier
						nxt_idxSel = `POD_IDX_FIRST;
					end else if (byteData == `POD_PFX_IDX2) begin
						nxt_idxSel = `POD_IDX_SECOND;
					end else if (idxDec.needDisp) begin
						nxt_pend = idxDec.op;
						nxt_immLeft = idxDec.immCnt;
						nxt_immHigh = 1'b0;
						nxt_state = ST_DISP;
					end else if (idxDec.immCnt != `POD_IMM_NONE) begin
						nxt_pend = idxDec.op;
						nxt_immLeft = idxDec.immCnt;
						nxt_immHigh = 1'b0;
						nxt_state = ST_IMM;
					end else begin
						emit = 1'b1;
						emitOp = idxDec.op;
						nxt_state = ST_FIRST;
					end
				end
				ST_XDISP: begin
					// displacement comes before the operation byte
					nxt_xdisp = byteData;
					nxt_state = ST_XOP;
				end
				ST_XOP: begin
					// (RULE20) bit page at first index plus d
					// (RULE21) bit page at second index plus d
					emit = 1'b1;
					emitOp = bitDec.op;
					emitOp.idxSel = idxSel_ff;
					emitOp.disp = xdisp_ff;
					nxt_state = ST_FIRST;
				end
				ST_DISP: begin
					// (RULE17) signed displacement byte
					nxt_pend.disp = byteData;
					if (immLeft_ff != `POD_IMM_NONE) begin
						nxt_state = ST_IMM;
					end else begin
						emit = 1'b1;
						emitOp = pend_ff;
						emitOp.disp = byteData;
						nxt_state = ST_FIRST;
					end
				end
				ST_IMM: begin
					// low byte first, then high byte
					emitOp = pend_ff;
					if (immHigh_ff) begin
						emitOp.imm[15:8] = byteData;
					end else begin
						emitOp.imm[7:0] = byteData;
					end
					nxt_pend = emitOp;
					nxt_immLeft = immLeft_ff - 2'h1;
					nxt_immHigh = 1'b1;
					if (immLeft_ff == `POD_IMM_BYTE) begin
						emit = 1'b1;
						nxt_state = ST_FIRST;
					end
				end
				default: nxt_state = ST_FIRST;
			endcase
		end
	end

	// ------------------------------------------------------------
	// sequencing registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_FIRST;
			idxSel_ff <= `POD_IDX_NONE;
		end else begin
			state_ff <= nxt_state;
			idxSel_ff <= nxt_idxSel;
		end
	end

	// operand collection; cleared at reset so no stale data leaks
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_ff <= '0;
			immLeft_ff <= `POD_IMM_NONE;
			immHigh_ff <= 1'b0;
			xdisp_ff <= 8'h00;
		end else begin
			pend_ff <= nxt_pend;
			immLeft_ff <= nxt_immLeft;
			immHigh_ff <= nxt_immHigh;
			xdisp_ff <= nxt_xdisp;
		end
	end

	// ------------------------------------------------------------
	// output and held mode
	// ------------------------------------------------------------
	// the strobe lasts one cycle; the operation word stays until
	// the next one replaces it
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			opValid_ff <= 1'b0;
			op_ff <= '0;
		end else begin
			opValid_ff <= emit;
			if (emit) begin
				op_ff <= emitOp;
			end
		end
	end

	// (RULE10) hold mode for interrupt handling
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			imode_ff <= `POD_IMODE_RST;
		end else if (emit && emitOp.kind == OP_IMSET) begin
			// row 4 is mode 0, row 5 col 6 mode 1, col E mode 2
			imode_ff <= emitOp.opcode[4] ?
				(emitOp.opcode[3] ? 2'h2 : 2'h1) : 2'h0;
		end
	end

	assign opValid = opValid_ff;
	assign op = op_ff;
	assign intMode = imode_ff;
	assign busy = (state_ff != ST_FIRST);
endmodule

// [verification/pod_decoder_monitor.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker for the prefixed opcode decoder
// ----------------------------------------------------------------
module pod_decoder_monitor import pod_pkg::*; (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic flush,
	input wire logic opValid,
	input pod_op_t op,
	input wire logic [1:0] intMode,
	input wire logic busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic take; // a byte is consumed at this edge
	assign take = byteValid && !flush;
	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	a_bit_prefix_pair: assert property (
		!busy && take && byteData == 8'hcb ##1 take
		|=> opValid && op.opcode == $past(byteData))
		else $error("bit page byte not emitted");
	a_emit_after_byte: assert property (
		opValid |-> $past(take))
		else $error("op emitted without a byte");
	a_second_index_sel: assert property (
		!busy && take && byteData == 8'hfd ##1 take && byteData == 8'h23
		|=> opValid && op.idxSel == 2'h2)
		else $error("second index not selected");
	// ----------------------------------------------------------------
	// field relations of the emitted op
	// ----------------------------------------------------------------
	a_shift_row: assert property (
		opValid && op.kind == OP_LSR
		|-> op.opcode[7:3] == 5'h07 && op.regSel == op.opcode[2:0])
		else $error("shift row mismatch");
	a_test_rows: assert property (
		opValid && op.kind == OP_BTEST
		|-> op.opcode[7:6] == 2'h1 && op.bitNum == op.opcode[5:3])
		else $error("bit test rows mismatch");
	a_clear_rows: assert property (
		opValid && op.kind == OP_BCLR
		|-> op.opcode[7:6] == 2'h2 && op.bitNum == op.opcode[5:3])
		else $error("bit clear rows mismatch");
	a_force_rows: assert property (
		opValid && op.kind == OP_BSET
		|-> op.opcode[7:6] == 2'h3 && op.bitNum == op.opcode[5:3])
		else $error("bit force rows mismatch");
	a_wide_sub_pair: assert property (
		opValid && op.kind == OP_SUBW |-> op.opcode[7:6] == 2'h1
		&& op.opcode[3:0] == 4'h2 && op.pairSel == op.opcode[5:4])
		else $error("wide subtract pair mismatch");
	a_mode_value: assert property (
		opValid && op.kind == OP_IMSET |-> intMode ==
		(op.opcode[4] ? (op.opcode[3] ? 2'h2 : 2'h1) : 2'h0))
		else $error("interrupt mode value mismatch");
	a_mode_held: assert property (
		$changed(intMode) |-> opValid && op.kind == OP_IMSET)
		else $error("interrupt mode changed alone");
	a_index_step: assert property (
		opValid && op.kind == OP_XINC
		|-> op.opcode == 8'h23 && op.idxSel != 2'h0)
		else $error("index increment mismatch");
	a_indexed_memory: assert property (
		opValid && op.idxSel != 2'h0
		&& op.kind inside {OP_BTEST, OP_BCLR, OP_BSET, OP_LSR}
		|-> op.opcode[2:0] == 3'h6)
		else $error("indexed bit op without memory operand");
endmodule
bind prefixed_opcode_decoder pod_decoder_monitor pod_decoder_monitor_i (
	.ref_clk(ref_clk), .arst_n(arst_n), .byteValid(byteValid),
	.byteData(byteData), .flush(flush), .opValid(opValid), .op(op),
	.intMode(intMode), .busy(busy));

// [verification/pod_fetch_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// fetch side model: hands bytes over on the falling edge
// ----------------------------------------------------------------
module pod_fetch_model (
	input wire logic ref_clk,
	output logic byteValid,
	output logic [7:0] byteData,
	output logic flush
);
	logic slow = 1'b0; // slow fetch: one idle cycle before each byte
	initial begin
		byteValid = 1'b0;
		byteData = 8'h00;
		flush = 1'b0;
	end
	// idle cycles flip the data so a stale byte never passes as valid
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			byteValid = 1'b0;
			flush = 1'b0;
			byteData = ~byteData;
		end
	endtask
	// one byte, taken at the following rising edge
	task automatic put(input logic [7:0] b);
		if (slow)
			idle(1);
		@(negedge ref_clk);
		byteValid = 1'b1;
		flush = 1'b0;
		byteData = b;
	endtask
	// abandon a partial sequence
	task automatic drop();
		@(negedge ref_clk);
		byteValid = 1'b0;
		flush = 1'b1;
	endtask
endmodule

// [verification/prefixed_opcode_decoder_test.sv]
`timescale 1ns/1ns
module prefixed_opcode_decoder_test import pod_pkg::*; ;
	logic ref_clk = 1'b0; // core clock, 8 ns period
	logic arst_n = 1'b0; // held low for the first cycles
	logic byteValid;
	logic [7:0] byteData;
	logic flush;
	logic opValid;
	pod_op_t op;
	logic [1:0] intMode;
	logic busy;
	int num_errors = 0;
	int checks = 0;
	always #4 ref_clk = ~ref_clk;
	pod_fetch_model pod_fetch_model_i (.ref_clk(ref_clk),
		.byteValid(byteValid), .byteData(byteData), .flush(flush));
	prefixed_opcode_decoder prefixed_opcode_decoder_i (.ref_clk(ref_clk),
		.arst_n(arst_n), .byteValid(byteValid), .byteData(byteData),
		.flush(flush), .opValid(opValid), .op(op), .intMode(intMode),
		.busy(busy));
	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// feed one instruction; the op must pulse one cycle later
	task automatic run(input logic [7:0] b[$]);
		foreach (b[i])
			pod_fetch_model_i.put(b[i]);
		pod_fetch_model_i.idle(1);
		chk("opValid", opValid, 1'b1);
	endtask
	task automatic ki(input pod_kind_t k, input logic [1:0] s);
		chk("kind", op.kind, k);
		chk("index", op.idxSel, s);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic s_bit_page();
		logic [7:0] b;
		pod_kind_t k;
		for (int r = 3; r < 16; r++) begin
			for (int c = 0; c < 16; c++) begin
				b = 8'(r * 16 + c);
				k = r > 11 ? OP_BSET : r > 7 ? OP_BCLR : r > 3 ? OP_BTEST :
					c > 7 ? OP_LSR : OP_NOP;
				run('{8'hcb, b});
				chk("bit kind", op.kind, k);
				if (k != OP_NOP) begin
					chk("bit number", op.bitNum, b[5:3]);
					chk("operand", op.regSel, b[2:0]);
				end
			end
		end
	endtask
	task automatic s_ext_page();
		logic [7:0] eb[18] = '{8'h40, 8'h79, 8'h42, 8'h7a, 8'h44, 8'h45,
			8'h4d, 8'h47, 8'h57, 8'h4f, 8'h5f, 8'h67, 8'h6f, 8'ha0, 8'ha9,
			8'hb2, 8'hbb, 8'h77};
		pod_kind_t ek[18] = '{OP_PIN, OP_POUT, OP_SUBW, OP_ADDW, OP_NEG,
			OP_RETNMI, OP_RETIRQ, OP_A2VEC, OP_VEC2A, OP_A2RFSH, OP_RFSH2A,
			OP_NROTR, OP_NROTL, OP_BCOPY, OP_BCMP, OP_BIN, OP_BOUT, OP_NOP};
		for (int i = 0; i < 18; i++) begin
			run('{8'hed, eb[i]});
			chk("ext kind", op.kind, ek[i]);
			if (i < 2)
				chk("port reg", op.regSel, eb[i][5:3]);
			else if (i < 4)
				chk("pair", op.pairSel, eb[i][5:4]);
			else if (i > 12 && i < 17) begin
				chk("down", op.blkDown, eb[i][3]);
				chk("repeat", op.blkRepeat, eb[i][4]);
			end
		end
		run('{8'hed, 8'h53, 8'h34, 8'h12});
		chk("store kind", op.kind, OP_STPAIR);
		chk("store addr", op.imm, 16'h1234);
		run('{8'hed, 8'h7b, 8'h78, 8'h56});
		chk("load kind", op.kind, OP_LDPAIR);
		chk("load pair", op.pairSel, 2'h3);
	endtask
	task automatic s_modes();
		logic [7:0] mb[3] = '{8'h5e, 8'h46, 8'h56};
		logic [1:0] ml[3] = '{2'h2, 2'h0, 2'h1};
		for (int i = 0; i < 3; i++) begin
			run('{8'hed, mb[i]});
			chk("mode", intMode, ml[i]);
		end
		pod_fetch_model_i.put(8'hed);
		pod_fetch_model_i.drop();
		pod_fetch_model_i.idle(1);
		chk("busy", busy, 1'b0);
		chk("no emit", opValid, 1'b0);
		pod_fetch_model_i.slow = 1'b1;
		run('{8'hcb, 8'h00});
		pod_fetch_model_i.slow = 1'b0;
		chk("rotate kind", op.kind, OP_ROTSH);
		chk("mode held", intMode, 2'h1);
	endtask
	task automatic s_index();
		logic [7:0] xb[5] = '{8'he1, 8'he3, 8'he5, 8'he9, 8'hf9};
		pod_kind_t xk[5] = '{OP_XPOP, OP_XEXSP, OP_XPUSH, OP_XJP, OP_XLDSP};
		for (int i = 0; i < 5; i++) begin
			run('{8'hdd, xb[i]});
			ki(xk[i], 2'h1);
		end
		run('{8'hdd, 8'h21, 8'h34, 8'h12});
		ki(OP_XLDIMM, 2'h1);
		chk("imm", op.imm, 16'h1234);
		run('{8'hfd, 8'h2a, 8'hcd, 8'hab});
		ki(OP_XLDABS, 2'h2);
		chk("imm", op.imm, 16'habcd);
		run('{8'hdd, 8'h22, 8'h01, 8'h80});
		ki(OP_XSTABS, 2'h1);
		chk("imm", op.imm, 16'h8001);
		run('{8'hdd, 8'h2b});
		ki(OP_XDEC, 2'h1);
		run('{8'hdd, 8'hfd, 8'h23});
		ki(OP_XINC, 2'h2);
		run('{8'hfd, 8'h23});
		ki(OP_XINC, 2'h2);
		run('{8'hfd, 8'h29});
		ki(OP_XADD, 2'h2);
		run('{8'hdd, 8'h36, 8'h80, 8'h5a});
		ki(OP_XSUBST, 2'h1);
		chk("disp", op.disp, 8'h80);
		chk("imm", op.imm[7:0], 8'h5a);
		run('{8'hfd, 8'h7e, 8'hff});
		chk("disp", op.disp, 8'hff);
		chk("index", op.idxSel, 2'h2);
		run('{8'hdd, 8'h00});
		chk("kind", op.kind, OP_NOP);
	endtask
	task automatic s_idx_bit();
		run('{8'hdd, 8'hcb, 8'h05, 8'h46});
		ki(OP_BTEST, 2'h1);
		chk("disp", op.disp, 8'h05);
		run('{8'hfd, 8'hcb, 8'hfb, 8'hfe});
		ki(OP_BSET, 2'h2);
		chk("bit", op.bitNum, 3'h7);
		chk("disp", op.disp, 8'hfb);
		run('{8'hfd, 8'hcb, 8'h10, 8'h3e});
		ki(OP_LSR, 2'h2);
		run('{8'hfd, 8'hcb, 8'h10, 8'h8e});
		ki(OP_BCLR, 2'h2);
		run('{8'hdd, 8'hcb, 8'h22, 8'h47});
		chk("kind", op.kind, OP_NOP);
		chk("disp", op.disp, 8'h22);
	endtask
	// reset in mid-sequence clears state, mode and the op word
	task automatic s_reset();
		pod_fetch_model_i.put(8'hed);
		pod_fetch_model_i.idle(1);
		chk("busy", busy, 1'b1);
		arst_n = 1'b0;
		pod_fetch_model_i.idle(1);
		chk("reset busy", busy, 1'b0);
		chk("reset mode", intMode, 2'h0);
		chk("reset op", op.kind, OP_NOP);
		arst_n = 1'b1;
		run('{8'h3e});
		chk("base kind", op.kind, OP_BASE);
		chk("base opcode", op.opcode, 8'h3e);
	endtask
	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("reset valid", opValid, 1'b0);
		arst_n = 1'b1;
		s_bit_page();
		s_ext_page();
		s_modes();
		s_reset();
		s_index();
		s_idx_bit();
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		num_errors++;
		tally_and_finish();
	end
endmodule
